/* design/tsp_port.sv */
/*
 * Timed serialising I/O port: one port of width 1..32 with counter,
 * timestamp, transfer register, strobes and conditions; a one-bit port
 * on pin 0; six clock blocks as enable pulses. Assumes an Avalon-MM
 * master on clk_in and an external pad ring that resolves pin enables.
 */
// Contract
// - Port drives pins or samples, optionally conditioned
// - All pins of a port share direction
// - Port widths 1, 4, 8, 16, 32
// - Open collector: zero pulls low, one floats
// - Processor port access completes in one cycle; here the bus answers one cycle after the request, with one wait state
// - Data passes serdes and transfer register
// - 16-bit counter schedules pin transfers
// - Counter readable; transfer waits for time
// - Counter captured as timestamp per transfer
// - Enabled link takes shared pins
// - Narrower enabled port wins shared pins
// - Wider port keeps its unshared pins
// - Port always transfers at nominal width
// - Six clock blocks, block zero 100 MHz
// - Clock block sourced from one-bit port
// - Optional divider on one-bit port clock
// - Accept and generate ready strobes
// - After reset ports use clock block zero
// - Pin conditions raise events, not interrupts
// - Pull-downs enabled while in reset
`timescale 1ns/100ps
`default_nettype none

module tsp_port
    import tsp_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        rst_b_in,
    input  wire logic [7:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    input  wire logic [3:0]  avs_byteenable_in,
    output var  logic [31:0] avs_readdata_out,
    output var  logic        avs_waitrequest_out,
    input  wire logic [31:0] pin_in,
    output var  logic [31:0] pin_out,
    output var  logic [31:0] pin_oe_out,
    output var  logic        pin_pulldown_out,
    input  wire logic        link_en_in,
    input  wire logic [1:0]  link_pin_out_in,
    input  wire logic [1:0]  link_pin_oe_in,
    input  wire logic        strobe_from_outside_in,
    output var  logic        strobe_to_outside_out,
    output var  logic        port_event_out
);

    tsp_state_s  q;
    tsp_state_s  d;
    logic        req;
    logic        fin;
    logic        pa_tick;
    logic        cap;
    logic        shift_go;
    logic        dir_out;
    logic [31:0] a_own;

    function automatic logic [5:0] wid_bits(input logic [2:0] c);
        logic [5:0] r;
        r = 6'h20;
        case (c)
            W_1:     r = 6'h01;
            W_4:     r = 6'h04;
            W_8:     r = 6'h08;
            W_16:    r = 6'h10;
            default: r = 6'h20;
        endcase
        return r;
    endfunction

    function automatic logic [5:0] n_chunks(input logic [2:0] c);
        logic [5:0] r;
        r = 6'h01;
        case (c)
            W_1:     r = 6'h20;
            W_4:     r = 6'h08;
            W_8:     r = 6'h04;
            W_16:    r = 6'h02;
            default: r = 6'h01;
        endcase
        return r;
    endfunction

    function automatic logic [31:0] wid_mask(input logic [2:0] c);
        logic [31:0] r;
        r = 32'hFFFFFFFF;
        if (wid_bits(c) != 6'h20) begin
            r = (32'h00000001 << wid_bits(c)) - 32'h00000001;
        end
        return r;
    endfunction

    function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    always_comb begin
        logic                ref_tick;
        logic                pb_rise;
        logic                src;
        logic [N_CLKB-1:0]   tick;
        logic [2:0]          sel;
        logic [2:0]          code;
        logic [5:0]          w;
        logic [31:0]         m;
        logic [31:0]         pins;
        logic [31:0]         nxt;
        logic                en;
        logic                t_ok;
        logic                r_ok;
        logic                c_ok;
        logic [2:0]          idx;
        logic [3:0]          acc;
        logic [31:0]         pv;
        logic [31:0]         poe;
        ref_tick = 1'b0;
        pb_rise  = 1'b0;
        src      = 1'b0;
        tick     = '0;
        sel      = q.ctrl[CTRL_CLK +: 3];
        code     = q.ctrl[CTRL_WID +: 3];
        w        = wid_bits(code);
        m        = wid_mask(code);
        pins     = q.pin_sync[1] & m;
        nxt      = '0;
        en       = q.ctrl[CTRL_EN];
        t_ok     = 1'b0;
        r_ok     = 1'b0;
        c_ok     = 1'b0;
        idx      = 3'(avs_address_in - OFS_CLKB1 >> 2);
        acc      = '0;
        pv       = '0;
        poe      = '0;
        d        = q;
        d.pin_pd     = 1'b0;
        d.event_out  = 1'b0;
        d.strobe_out = 1'b0;
        cap      = 1'b0;
        shift_go = 1'b0;
        dir_out  = q.ctrl[CTRL_OUT];

        // Pins and strobe cross in through two flops
        d.pin_sync[0] = pin_in;
        d.pin_sync[1] = q.pin_sync[0];
        d.stb_sync[0] = strobe_from_outside_in;
        d.stb_sync[1] = q.stb_sync[0];
        d.pb_prev     = q.pin_sync[1][0];
        pb_rise       = q.pin_sync[1][0] & ~q.pb_prev;

        // Reference block averages 100 MHz as 2 enables in 5 cycles
        acc = {1'b0, q.ref_acc} + {1'b0, REF_STEP};
        if (acc >= {1'b0, REF_MOD}) begin
            ref_tick = 1'b1;
            acc      = acc - {1'b0, REF_MOD};
        end
        d.ref_acc = acc[2:0];
        tick[0]   = ref_tick;
        for (int i = 1; i < N_CLKB; i++) begin
            src = q.cb_cfg[i-1][CB_SRC] ? pb_rise : ref_tick;
            if (src) begin
                if (q.cb_cfg[i-1][7:0] == 8'h00 ||
                    q.cb_cfg[i-1][7:0] == 8'(q.cb_cnt[i-1] + 8'h01)) begin
                    tick[i]       = 1'b1;
                    d.cb_cnt[i-1] = 8'h00;
                end else begin
                    d.cb_cnt[i-1] = 8'(q.cb_cnt[i-1] + 8'h01);
                end
            end
        end
        pa_tick = 1'b0;
        if (sel < 3'(N_CLKB)) begin
            pa_tick = tick[sel];
        end
        if (pa_tick) begin
            d.cnt = 16'(q.cnt + 16'h0001);
        end

        // Bus: answer one cycle after the request is seen
        req       = avs_read_in | avs_write_in;
        fin       = req & ~q.waitreq;
        d.waitreq = ~(req & q.waitreq);
        if (req && q.waitreq) begin
            d.rdata = '0;
            case (avs_address_in)
                OFS_CTRL:   d.rdata = q.ctrl;
                OFS_DATA:   d.rdata = q.tr;
                OFS_TIME:   d.rdata = {16'h0000, q.cnt};
                OFS_STAMP:  d.rdata = {16'h0000, q.stamp};
                OFS_STATUS: d.rdata = {29'h00000000, q.pin_sync[1][0], q.eng != ENG_IDLE, q.tr_full};
                OFS_COND:   d.rdata = q.cond;
                OFS_PORTB:  d.rdata = {28'h0000000, q.pb_cfg};
                default: begin
                    if (avs_address_in >= OFS_CLKB1 && avs_address_in <= OFS_CLKB_LAST) begin
                        d.rdata = {23'h000000, q.cb_cfg[idx]};
                    end
                end
            endcase
        end
        if (fin && avs_write_in) begin
            case (avs_address_in)
                OFS_CTRL:  d.ctrl = be_merge(q.ctrl, avs_writedata_in, avs_byteenable_in);
                OFS_TIME:  d.time_at = 16'(be_merge({16'h0000, q.time_at}, avs_writedata_in,
                                                    avs_byteenable_in));
                OFS_COND:  d.cond = be_merge(q.cond, avs_writedata_in, avs_byteenable_in);
                OFS_PORTB: d.pb_cfg = 4'(be_merge({28'h0000000, q.pb_cfg}, avs_writedata_in,
                                                  avs_byteenable_in));
                OFS_DATA: begin
                    // A full transfer register refuses the write
                    if (dir_out && !q.tr_full) begin
                        d.tr      = be_merge(q.tr, avs_writedata_in, avs_byteenable_in);
                        d.tr_full = 1'b1;
                    end
                end
                default: begin
                    if (avs_address_in >= OFS_CLKB1 && avs_address_in <= OFS_CLKB_LAST) begin
                        d.cb_cfg[idx] = 9'(be_merge({23'h000000, q.cb_cfg[idx]}, avs_writedata_in,
                                                    avs_byteenable_in));
                    end
                end
            endcase
        end
        if (fin && avs_read_in && avs_address_in == OFS_DATA && !dir_out) begin
            d.tr_full = 1'b0;
        end

        // Transfer engine; it runs after the bus so a capture beats a read-clear
        t_ok = ~q.ctrl[CTRL_TIMED] | (q.cnt == q.time_at);
        r_ok = ~q.ctrl[CTRL_RDYIN] | q.stb_sync[1];
        case (q.ctrl[CTRL_COND +: 2])
            COND_EQ: c_ok = (pins == (q.cond & m));
            COND_NE: c_ok = (pins != (q.cond & m));
            default: c_ok = 1'b1;
        endcase
        unique case (q.eng)
            ENG_IDLE: begin
                if (en && dir_out && q.tr_full) begin
                    d.serdes  = q.tr;
                    d.tr_full = 1'b0;
                    d.left    = n_chunks(code);
                    d.eng     = ENG_WAIT;
                end else if (en && !dir_out) begin
                    d.serdes = '0;
                    d.left   = n_chunks(code);
                    d.eng    = ENG_WAIT;
                end
            end
            ENG_WAIT, ENG_SHIFT: begin
                shift_go = en & pa_tick & r_ok &
                           ((q.eng == ENG_SHIFT) | (t_ok & (dir_out | c_ok)));
                cap      = shift_go & (q.eng == ENG_WAIT);
                if (!en) begin
                    d.eng = ENG_IDLE;
                end else if (shift_go) begin
                    if (cap) begin
                        d.stamp     = q.cnt;
                        d.event_out = ~dir_out & (q.ctrl[CTRL_COND +: 2] != COND_NONE);
                    end
                    if (dir_out) begin
                        d.pa_val     = q.serdes & m;
                        d.serdes     = q.serdes >> w;
                        d.strobe_out = q.ctrl[CTRL_RDYOUT];
                    end else begin
                        nxt      = (q.serdes >> w) | (pins << (6'h20 - w));
                        d.serdes = nxt;
                    end
                    d.left = 6'(q.left - 6'h01);
                    if (q.left == 6'h01) begin
                        d.eng = ENG_IDLE;
                        if (!dir_out) begin
                            d.tr      = nxt;
                            d.tr_full = 1'b1;
                        end
                    end else begin
                        d.eng = ENG_SHIFT;
                    end
                end
            end
            default: d.eng = ENG_IDLE;
        endcase

        // Pin ownership: link over one-bit port over the wide port
        a_own = en ? m : '0;
        if (q.pb_cfg[PB_EN]) begin
            a_own[0] = 1'b0;
        end
        if (link_en_in) begin
            a_own = a_own & ~LINK_PIN_MASK;
        end
        poe = dir_out ? a_own : '0;
        pv  = d.pa_val; // Same cycle as the strobe
        if (q.ctrl[CTRL_OC]) begin
            poe = poe & ~d.pa_val;
            pv  = '0;
        end
        if (q.pb_cfg[PB_EN]) begin
            poe[0] = q.pb_cfg[PB_OUT] & ~(q.pb_cfg[PB_OC] & q.pb_cfg[PB_VAL]);
            pv[0]  = q.pb_cfg[PB_VAL] & ~q.pb_cfg[PB_OC];
        end
        if (link_en_in) begin
            poe[31:30] = link_pin_oe_in;
            pv[31:30]  = link_pin_out_in;
        end
        d.pins.val = pv;
        d.pins.oe  = poe;
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            q <= TSP_STATE_RST;
        end else begin
            q <= d;
        end
    end

    assign avs_readdata_out      = q.rdata;
    assign avs_waitrequest_out   = q.waitreq;
    assign pin_out               = q.pins.val;
    assign pin_oe_out            = q.pins.oe;
    assign pin_pulldown_out      = q.pin_pd;
    assign strobe_to_outside_out = q.strobe_out;
    assign port_event_out        = q.event_out;

    default clocking cb_def @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    property p_bus_answer;
        (req && q.waitreq) |=> !q.waitreq ##1 q.waitreq;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("bus answer not in one cycle");

    property p_cnt_step;
        pa_tick |=> q.cnt == 16'($past(q.cnt) + 16'h0001);
    endproperty
    a_cnt_step: assert property (p_cnt_step) else $error("counter did not step");

    property p_stamp;
        cap |=> q.stamp == $past(q.cnt);
    endproperty
    a_stamp: assert property (p_stamp) else $error("timestamp not captured");

    property p_timed;
        (cap && q.ctrl[CTRL_TIMED]) |-> q.cnt == q.time_at;
    endproperty
    a_timed: assert property (p_timed) else $error("timed transfer at wrong count");

    property p_link;
        link_en_in |=> q.pins.oe[31:30] == $past(link_pin_oe_in);
    endproperty
    a_link: assert property (p_link) else $error("link lost shared pins");

    property p_narrow;
        (q.pb_cfg[PB_EN] && !q.pb_cfg[PB_OUT]) |=> !q.pins.oe[0];
    endproperty
    a_narrow: assert property (p_narrow) else $error("wide port drove pin 0");

    property p_oc;
        q.ctrl[CTRL_OC] |=> (q.pins.val & $past(a_own)) == '0;
    endproperty
    a_oc: assert property (p_oc) else $error("open collector drove high");

    property p_dir_in;
        !dir_out |=> (q.pins.oe & $past(a_own)) == '0;
    endproperty
    a_dir_in: assert property (p_dir_in) else $error("input port drove pins");

    property p_ready;
        (shift_go && q.ctrl[CTRL_RDYIN]) |-> q.stb_sync[1];
    endproperty
    a_ready: assert property (p_ready) else $error("transfer without ready strobe");

    c_out_word: cover property (q.eng == ENG_SHIFT && dir_out ##[1:40] q.eng == ENG_IDLE);
    c_in_event: cover property (q.event_out);
    c_timed: cover property (cap && q.ctrl[CTRL_TIMED]);
    c_link: cover property (link_en_in && q.pb_cfg[PB_EN]);

endmodule // tsp_port

`default_nettype wire

/* design/tsp_pkg.sv */
/*
 * Shared constants, enumerations and carrier types for the timed
 * serialising I/O port. Assumes a single 250 MHz system clock and an
 * Avalon-MM slave with byte addresses, one 32-bit word per register.
 */
package tsp_pkg;

    // System clock and reference clock rates
    localparam int unsigned CLK_MHZ   = 250;
    localparam int unsigned REF_MHZ   = 100;
    localparam int unsigned RATIO_GCD = 50;
    localparam logic [2:0]  REF_STEP  = 3'(REF_MHZ / RATIO_GCD);
    localparam logic [2:0]  REF_MOD   = 3'(CLK_MHZ / RATIO_GCD);
    localparam int unsigned N_CLKB    = 6;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_DATA      = 8'h04;
    localparam logic [7:0] OFS_TIME      = 8'h08;
    localparam logic [7:0] OFS_STAMP     = 8'h0C;
    localparam logic [7:0] OFS_STATUS    = 8'h10;
    localparam logic [7:0] OFS_COND      = 8'h14;
    localparam logic [7:0] OFS_PORTB     = 8'h18;
    localparam logic [7:0] OFS_CLKB1     = 8'h24;
    localparam logic [7:0] OFS_CLKB_LAST = 8'h34;

    // Control register fields
    localparam int unsigned CTRL_EN     = 0;
    localparam int unsigned CTRL_OUT    = 1;
    localparam int unsigned CTRL_OC     = 2;
    localparam int unsigned CTRL_WID    = 4;
    localparam int unsigned CTRL_CLK    = 8;
    localparam int unsigned CTRL_TIMED  = 12;
    localparam int unsigned CTRL_RDYIN  = 13;
    localparam int unsigned CTRL_RDYOUT = 14;
    localparam int unsigned CTRL_COND   = 16;
    localparam logic [31:0] CTRL_RST    = 32'h00000000;

    // One-bit port and clock block fields
    localparam int unsigned PB_EN  = 0;
    localparam int unsigned PB_OUT = 1;
    localparam int unsigned PB_OC  = 2;
    localparam int unsigned PB_VAL = 3;
    localparam int unsigned CB_SRC = 8;

    // Pins taken by the link when it is enabled
    localparam logic [31:0] LINK_PIN_MASK = 32'hC0000000;

    typedef enum logic [2:0] {
        W_1  = 3'h0,
        W_4  = 3'h1,
        W_8  = 3'h2,
        W_16 = 3'h3,
        W_32 = 3'h4
    } tsp_width_e;

    localparam logic [1:0] COND_NONE = 2'h0;
    localparam logic [1:0] COND_EQ   = 2'h1;
    localparam logic [1:0] COND_NE   = 2'h2;

    typedef enum logic [2:0] {
        ENG_IDLE  = 3'h1,
        ENG_WAIT  = 3'h2,
        ENG_SHIFT = 3'h4
    } tsp_eng_e;

    typedef struct packed {
        logic [31:0] val;
        logic [31:0] oe;
    } tsp_pins_s;

    typedef struct packed {
        logic [31:0]      ctrl;
        logic [31:0]      cond;
        logic [3:0]       pb_cfg;
        logic [4:0][8:0]  cb_cfg;
        logic [2:0]       ref_acc;
        logic [4:0][7:0]  cb_cnt;
        tsp_eng_e         eng;
        logic [31:0]      tr;
        logic             tr_full;
        logic [31:0]      serdes;
        logic [5:0]       left;
        logic [15:0]      cnt;
        logic [15:0]      time_at;
        logic [15:0]      stamp;
        logic [31:0]      pa_val;
        tsp_pins_s        pins;
        logic             pin_pd;
        logic             strobe_out;
        logic             event_out;
        logic [1:0][31:0] pin_sync;
        logic [1:0]       stb_sync;
        logic             pb_prev;
        logic             waitreq;
        logic [31:0]      rdata;
    } tsp_state_s;

    localparam tsp_state_s TSP_STATE_RST = '{
        ctrl: CTRL_RST, eng: ENG_IDLE, pin_pd: 1'b1, waitreq: 1'b1, default: '0};

endpackage

/* test/tsp_pad_model.sv */
/* Board-side model of the pads and the external strobe source.
   Assumes the bench commands external drive and strobe level. */
`timescale 1ns/100ps
`default_nettype none
module tsp_pad_model (
    input  wire logic [31:0] pin_out_in,
    input  wire logic [31:0] pin_oe_in,
    input  wire logic        pulldown_in,
    input  wire logic        clk_in,
    input  wire logic [31:0] drv_en_in,
    input  wire logic [31:0] drv_val_in,
    input  wire logic        stb_req_in,
    output var  logic [31:0] lvl_out,
    output var  logic        strobe_out
);
    logic [31:0] junk_q = 32'h55555555;
    // Floating pins toggle unless the pull-down is on, so a stale level never passes
    always @(posedge clk_in) junk_q <= ~junk_q;
    assign lvl_out = (pin_oe_in & pin_out_in) | (~pin_oe_in & drv_en_in & drv_val_in)
                   | (~pin_oe_in & ~drv_en_in & ~{32{pulldown_in}} & junk_q);
    assign strobe_out = stb_req_in;
endmodule // tsp_pad_model
`default_nettype wire

/* test/tsp_port_tb_top.sv */
/* Self-checking bench for the timed serialising port.
   Assumes the pad model as far side and block 0 at 2 ticks per 5 clocks. */
`timescale 1ns/100ps
`default_nettype none
module tsp_port_tb_top
    import tsp_pkg::*;
;
    logic        clk_in = 1'b0, rst_b = 1'b0, rd = 1'b0, wr = 1'b0, stb_req = 1'b0;
    logic        lnk_en = 1'b0, wtr, pd, stb, evt, stb_in;
    logic [1:0]  lnk_out = 2'h0, lnk_oe = 2'h0;
    logic [7:0]  adr = 8'h00, stb_byte = 8'h00;
    logic [31:0] wd = 32'h0, drv_en = 32'h0, drv_val = 32'h0, rdat, pout, poe, lvl, q, r;
    int          bad_count = 0, cmp_count = 0, stb_cnt = 0;

    tsp_port u_dut (.clk_in(clk_in), .rst_b_in(rst_b), .avs_address_in(adr), .avs_read_in(rd),
        .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(4'hF), .avs_readdata_out(rdat),
        .avs_waitrequest_out(wtr), .pin_in(lvl), .pin_out(pout), .pin_oe_out(poe),
        .pin_pulldown_out(pd), .link_en_in(lnk_en), .link_pin_out_in(lnk_out),
        .link_pin_oe_in(lnk_oe), .strobe_from_outside_in(stb_in),
        .strobe_to_outside_out(stb), .port_event_out(evt));
    tsp_pad_model u_pad (.pin_out_in(pout), .pin_oe_in(poe), .pulldown_in(pd), .clk_in(clk_in),
        .drv_en_in(drv_en), .drv_val_in(drv_val), .stb_req_in(stb_req), .lvl_out(lvl),
        .strobe_out(stb_in));

    initial begin
        forever #2 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        if (stb === 1'b1) begin
            stb_cnt++;
            stb_byte <= pout[7:0];
        end
    end

    task automatic chk(input string nm, input logic [63:0] s, input logic [63:0] e);
        cmp_count++;
        if (s !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Holds the request until waitrequest is sampled low
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] v);
        int n;
        n = 0;
        @(posedge clk_in);
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= ~w;
        @(posedge clk_in);
        while (wtr !== 1'b0 && n < 100) begin
            @(posedge clk_in);
            n++;
        end
        v = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
        chk("bus answer", 64'(n < 100), 64'h1);
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, r);
    endtask
    task automatic wait_pin(input string nm, input logic [63:0] m, input logic [63:0] e, input int lim);
        for (int i = 0; i < lim && ({poe, pout} & m) !== e; i++) @(posedge clk_in);
        chk(nm, {poe, pout} & m, e);
    endtask

    task automatic t_reset();
        // State is unknown until the first edge under reset
        repeat (16) @(posedge clk_in);
        chk("pd in reset", 64'(pd), 64'h1);
        chk("oe in reset", 64'(poe), 64'h0);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk_in);
        chk("pd after", 64'(pd), 64'h0);
        bus(1'b0, OFS_CTRL, 32'h0, q);
        chk("ctrl reset", 64'(q), 64'h0);
        bus(1'b0, 8'h40, 32'h0, q);
        chk("unmapped", 64'(q), 64'h0);
    endtask
    task automatic t_tick();
        bus(1'b0, OFS_TIME, 32'h0, q);
        repeat (100) @(posedge clk_in);
        bus(1'b0, OFS_TIME, 32'h0, r);
        // 103 edges at 2 ticks per 5 clocks
        chk("tick", 64'((16'(r - q) >= 16'd41) && (16'(r - q) <= 16'd42)), 64'h1);
    endtask
    task automatic t_out8();
        int s0;
        wreg(OFS_CTRL, 32'h00004023);
        s0 = stb_cnt;
        wreg(OFS_DATA, 32'h44332211);
        for (int k = 0; k < 4; k++) wait_pin("byte", 64'hFF, 64'(8'h11 * (k + 1)), 40);
        chk("oe byte", 64'(poe[7:0]), 64'hFF);
        repeat (10) @(posedge clk_in);
        chk("strobes", 64'(stb_cnt - s0), 64'h4);
        chk("strobe data", 64'(stb_byte), 64'h44);
    endtask
    task automatic t_oc();
        wreg(OFS_CTRL, 32'h00000017);
        wreg(OFS_DATA, 32'h00000005);
        wait_pin("oc low", {32'hF, 32'hF}, {32'hA, 32'h0}, 40);
        wait_pin("oc zero", {32'hF, 32'hF}, {32'hF, 32'h0}, 40);
        repeat (40) @(posedge clk_in);
    endtask
    task automatic t_timed();
        logic [15:0] tgt;
        wreg(OFS_CTRL, 32'h00001043);
        bus(1'b0, OFS_TIME, 32'h0, q);
        tgt = q[15:0] + 16'd60;
        wreg(OFS_TIME, 32'(tgt));
        wreg(OFS_DATA, 32'hA5A5A5A4);
        repeat (100) @(posedge clk_in);
        chk("early", 64'(pout === 32'hA5A5A5A4), 64'h0);
        wait_pin("timed", {64{1'b1}}, {32'hFFFFFFFF, 32'hA5A5A5A4}, 120);
        bus(1'b0, OFS_STAMP, 32'h0, q);
        chk("stamp", 64'(q[15:0]), 64'(tgt));
    endtask
    task automatic t_share();
        lnk_en <= 1'b1;
        lnk_oe <= 2'h3;
        lnk_out <= 2'h2;
        wreg(OFS_PORTB, 32'h0000000B);
        wreg(OFS_CTRL, 32'h00000043);
        wreg(OFS_DATA, 32'h15555554);
        wait_pin("shared", {64{1'b1}}, {32'hFFFFFFFF, 2'h2, 29'h0AAAAAAA, 1'b1}, 60);
        lnk_en <= 1'b0;
        wreg(OFS_PORTB, 32'h0);
    endtask
    task automatic t_ready();
        wreg(OFS_CTRL, 32'h00002043);
        wreg(OFS_DATA, 32'h0F0F0F0F);
        repeat (60) @(posedge clk_in);
        chk("held", 64'(pout === 32'h0F0F0F0F), 64'h0);
        stb_req <= 1'b1;
        wait_pin("released", 64'hFFFFFFFF, 64'h0F0F0F0F, 60);
        stb_req <= 1'b0;
    endtask
    task automatic t_input();
        drv_en <= 32'hFFFFFFFF;
        drv_val <= 32'h12345678;
        wreg(OFS_COND, 32'h12345678);
        wreg(OFS_CTRL, 32'h00010041);
        for (int i = 0; i < 200 && evt !== 1'b1; i++) @(posedge clk_in);
        chk("event", 64'(evt), 64'h1);
        chk("input oe", 64'(poe), 64'h0);
        bus(1'b0, OFS_STATUS, 32'h0, q);
        chk("full", 64'(q[0]), 64'h1);
        bus(1'b0, OFS_DATA, 32'h0, q);
        chk("word in", 64'(q), 64'h12345678);
    endtask
    task automatic t_clkb();
        // Pin 0 as a one-bit input port clocks block 1, divided by two
        wreg(OFS_PORTB, 32'h00000001);
        wreg(OFS_CLKB1, 32'h00000102);
        wreg(OFS_CTRL, 32'h00000100);
        bus(1'b0, OFS_TIME, 32'h0, q);
        repeat (6) begin
            drv_val[0] <= 1'b1;
            repeat (4) @(posedge clk_in);
            drv_val[0] <= 1'b0;
            repeat (4) @(posedge clk_in);
        end
        bus(1'b0, OFS_TIME, 32'h0, r);
        chk("pin clock", 64'(16'(r - q)), 64'h3);
        chk("pin0 oe", 64'(poe[0]), 64'h0);
    endtask

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_in);
        bad_count++;
        $display("CHECK FAILED watchdog expected end seen hang");
        complete_run();
    end
    initial begin
        t_reset();
        t_tick();
        t_out8();
        t_oc();
        t_timed();
        t_share();
        t_ready();
        t_input();
        t_clkb();
        complete_run();
    end
endmodule // tsp_port_tb_top
`default_nettype wire
